// File: common/icw_pkg.sv
// Purpose: Constants for the identify capability and timing word generator
// Assumes: APB slave with 8-bit byte address, 32-bit data
// Notes: Offsets, field positions, identify word indices and reset values
package icw_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GEOM0 = 8'h04;
  localparam logic [7:0] OFF_GEOM1 = 8'h08;
  localparam logic [7:0] OFF_LBA = 8'h0c;
  localparam logic [7:0] OFF_DMACYC = 8'h10;
  localparam logic [7:0] OFF_PIOCYC = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CAP = 8'h1c;

  // Control register fields
  localparam int CTRL_STBY_BIT = 0;
  localparam int CTRL_IORDY_BIT = 1;
  localparam int CTRL_PIO_LSB = 2;
  localparam int CTRL_APIO_LSB = 4;
  localparam int CTRL_MWLVL_LSB = 6;
  localparam int CTRL_MWSEL_LSB = 8;
  localparam int CTRL_MULT_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0300;
  localparam logic [31:0] CTRL_MASK = 32'h00ff_03ff;

  // Identify word indices
  localparam logic [7:0] W_CAPAB = 8'h31;
  localparam logic [7:0] W_PIOMODE = 8'h33;
  localparam logic [7:0] W_VALID = 8'h35;
  localparam logic [7:0] W_CYL = 8'h36;
  localparam logic [7:0] W_HEADS = 8'h37;
  localparam logic [7:0] W_SPT = 8'h38;
  localparam logic [7:0] W_CAPLO = 8'h39;
  localparam logic [7:0] W_CAPHI = 8'h3a;
  localparam logic [7:0] W_MULT = 8'h3b;
  localparam logic [7:0] W_LBALO = 8'h3c;
  localparam logic [7:0] W_LBAHI = 8'h3d;
  localparam logic [7:0] W_MWDMA = 8'h3f;
  localparam logic [7:0] W_APIO = 8'h40;
  localparam logic [7:0] W_DMAMIN = 8'h41;
  localparam logic [7:0] W_DMAREC = 8'h42;
  localparam logic [7:0] W_PIONF = 8'h43;
  localparam logic [7:0] W_PIOIO = 8'h44;

  // Identify word bit positions
  localparam int CAP_STBY_BIT = 13;
  localparam int CAP_IORDY_BIT = 11;
  localparam int CAP_IODIS_BIT = 10;
  localparam int CAP_LBA_BIT = 9;
  localparam int CAP_DMA_BIT = 8;
  localparam int VAL_GEOM_BIT = 0;
  localparam int VAL_ADV_BIT = 1;
  localparam int MULT_VALID_BIT = 8;
  localparam int MW_SEL_LSB = 8;
  localparam int PIO_MODE_LSB = 8;

  // Mode encodings
  localparam logic [1:0] PIO_MODE_MAX = 2'h2;
  localparam int MW_MODES = 3;
  localparam logic [1:0] MW_LVL_MODE1 = 2'h2;
endpackage

// File: rtl/icw_top.sv
// Purpose: Generates identify words 49 to 68 from configuration and card state
// Assumes: APB master per the protocol, inputs synchronous to clk_i
// Notes: Words are produced one cycle after id_rd_i; capacity lags writes by one cycle
//
// Notes on behaviour
// [RULE_01] Bit 13 reports standby timer per idle
// [RULE_02] Bit 11 reports IORDY support
// [RULE_03] Bit 10 always zero, IORDY not disableable
// [RULE_04] Bit 9 always one, LBA supported
// [RULE_05] Bit 8 always zero, legacy DMA banned
// [RULE_06] PIO mode in bits 15-8, 0 to 2
// [RULE_07] Validity bit 0 always one
// [RULE_08] Validity bit 1 marks words 64-70 valid
// [RULE_09] PIO 3 or faster sets validity bit 1
// [RULE_10] Current geometry reported, capacity is product
// [RULE_11] Multiple word: bit 8 set, count low
// [RULE_12] LBA capacity reports total user sectors
// [RULE_13] DMA selected field one-hot, modes 0-2
// [RULE_14] DMA support field cumulative, modes 0-2
// [RULE_15] DMA modes 3 and up never shown
// [RULE_16] Advanced PIO bits 0,1 for modes 3,4
// [RULE_17] Minimum DMA cycle supplied for mode 1+
// [RULE_18] Recommended DMA cycle never below minimum
// [RULE_19] PIO cycle without flow not below IORDY
// [RULE_20] Unsupported cycle fields read zero
// [RULE_21] Host uses at least recommended DMA cycle
// [RULE_22] IORDY PIO cycle gives fastest mode cycle
// [RULE_23] Reserved bits always read zero
`timescale 1ns/1ps
module icw_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic id_rd_i,
  input wire logic [7:0] id_idx_i,
  output logic [15:0] id_data_o,
  output logic id_vld_o
);

  // Byte-lane merge for partial APB writes
  function automatic logic [31:0] icw_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Larger of two cycle times, keeps ordering between paired fields
  function automatic logic [15:0] icw_max(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction

  // Mode count sizes the DMA vectors, so it must precede them
  localparam int MW_MODES_W = icw_pkg::MW_MODES;

  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;
  logic [31:0] ctrl_r;
  logic [31:0] geom0_r;
  logic [15:0] spt_r;
  logic [31:0] lba_r;
  logic [31:0] dmacyc_r;
  logic [31:0] piocyc_r;
  logic [31:0] cap_r;
  logic [47:0] prod_full;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [15:0] id_data_r;
  logic id_vld_r;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic [15:0] word_nxt;
  logic wr_access;
  logic [1:0] pio_eff;
  logic [1:0] apio;
  logic [1:0] mw_lvl;
  logic [1:0] mw_sel;
  logic [MW_MODES_W-1:0] mw_sup;
  logic [MW_MODES_W-1:0] mw_onehot;
  logic adv_valid;
  logic dma_cyc_sup;
  logic pio_cyc_sup;
  logic [15:0] w_capab;
  logic [15:0] w_valid;
  logic [15:0] w_dmamin;
  logic [15:0] w_dmarec;
  logic [15:0] w_pionf;
  logic [15:0] w_pioio;
  logic [31:0] spt_merged;

  // Reset released through two flops so release is clean against clk_i
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // Write lands only on the completing access edge
  assign wr_access = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

  // A function result cannot be sliced, so the lane merge goes through a net
  assign spt_merged = icw_merge({16'h0000, spt_r}, pwdata_i, pstrb_i);

  // Configuration registers written by software
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= icw_pkg::CTRL_RST;
      geom0_r <= 32'h0000_0000;
      spt_r <= 16'h0000;
      lba_r <= 32'h0000_0000;
      dmacyc_r <= 32'h0000_0000;
      piocyc_r <= 32'h0000_0000;
    end else if (wr_access) begin
      case (paddr_i)
        icw_pkg::OFF_CTRL: begin
          ctrl_r <= icw_merge(ctrl_r, pwdata_i, pstrb_i) & icw_pkg::CTRL_MASK;
        end
        icw_pkg::OFF_GEOM0: begin
          geom0_r <= icw_merge(geom0_r, pwdata_i, pstrb_i);
        end
        icw_pkg::OFF_GEOM1: begin
          spt_r <= spt_merged[15:0];
        end
        icw_pkg::OFF_LBA: begin
          lba_r <= icw_merge(lba_r, pwdata_i, pstrb_i);
        end
        icw_pkg::OFF_DMACYC: begin
          dmacyc_r <= icw_merge(dmacyc_r, pwdata_i, pstrb_i);
        end
        icw_pkg::OFF_PIOCYC: begin
          piocyc_r <= icw_merge(piocyc_r, pwdata_i, pstrb_i);
        end
        default: begin
        end
      endcase
    end
  end

  // Capacity is recomputed every cycle, so it trails geometry by one cycle at most
  assign prod_full = 48'(geom0_r[15:0]) * 48'(geom0_r[31:16]) * 48'(spt_r);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= 32'h0000_0000;
    end else begin
      cap_r <= prod_full[31:0]; // RULE_10
    end
  end

  // Mode decoding from control fields
  assign apio = ctrl_r[icw_pkg::CTRL_APIO_LSB +: 2];
  assign mw_lvl = ctrl_r[icw_pkg::CTRL_MWLVL_LSB +: 2];
  assign mw_sel = ctrl_r[icw_pkg::CTRL_MWSEL_LSB +: 2];
  // Reserved code 3 is never reported; clamp to the fastest legal mode
  assign pio_eff = (ctrl_r[icw_pkg::CTRL_PIO_LSB +: 2] > icw_pkg::PIO_MODE_MAX) ?
                   icw_pkg::PIO_MODE_MAX : ctrl_r[icw_pkg::CTRL_PIO_LSB +: 2]; // RULE_06

  // Per-mode support and selection; only modes 0 to 2 exist in this word
  for (genvar m = 0; m < MW_MODES_W; m++) begin : g_mw
    assign mw_sup[m] = (mw_lvl > 2'(m)); // RULE_14
    // A mode that is not supported cannot be shown as selected
    assign mw_onehot[m] = (mw_sel == 2'(m)) & mw_sup[m]; // RULE_13
  end

  // Words 64-70 are valid when advanced PIO or any DMA mode is supported
  assign adv_valid = (apio != 2'h0) | (mw_lvl != 2'h0); // RULE_08 RULE_09
  assign dma_cyc_sup = (mw_lvl >= icw_pkg::MW_LVL_MODE1);
  assign pio_cyc_sup = (apio != 2'h0);

  // Capability word, fixed bits hard wired
  always_comb begin
    w_capab = 16'h0000; // RULE_23
    w_capab[icw_pkg::CAP_STBY_BIT] = ctrl_r[icw_pkg::CTRL_STBY_BIT]; // RULE_01
    w_capab[icw_pkg::CAP_IORDY_BIT] = ctrl_r[icw_pkg::CTRL_IORDY_BIT]; // RULE_02
    w_capab[icw_pkg::CAP_IODIS_BIT] = 1'b0; // RULE_03
    w_capab[icw_pkg::CAP_LBA_BIT] = 1'b1; // RULE_04
    w_capab[icw_pkg::CAP_DMA_BIT] = 1'b0; // RULE_05
  end

  // Validity word
  always_comb begin
    w_valid = 16'h0000;
    w_valid[icw_pkg::VAL_GEOM_BIT] = 1'b1; // RULE_07
    w_valid[icw_pkg::VAL_ADV_BIT] = adv_valid; // RULE_08
  end

  // Cycle time fields, zero when the backing mode is absent
  assign w_dmamin = dma_cyc_sup ? dmacyc_r[15:0] : 16'h0000; // RULE_17 RULE_20
  assign w_dmarec = dma_cyc_sup ? icw_max(dmacyc_r[31:16], dmacyc_r[15:0]) :
                    16'h0000; // RULE_18 RULE_20
  assign w_pioio = pio_cyc_sup ? piocyc_r[31:16] : 16'h0000; // RULE_22 RULE_20
  assign w_pionf = pio_cyc_sup ? icw_max(piocyc_r[15:0], piocyc_r[31:16]) :
                   16'h0000; // RULE_19 RULE_20

  // Identify word select; unlisted indices read zero
  always_comb begin
    word_nxt = 16'h0000;
    case (id_idx_i)
      icw_pkg::W_CAPAB: begin
        word_nxt = w_capab;
      end
      icw_pkg::W_PIOMODE: begin
        word_nxt[icw_pkg::PIO_MODE_LSB +: 8] = {6'h00, pio_eff}; // RULE_06
      end
      icw_pkg::W_VALID: begin
        word_nxt = w_valid;
      end
      icw_pkg::W_CYL: begin
        word_nxt = geom0_r[15:0]; // RULE_10
      end
      icw_pkg::W_HEADS: begin
        word_nxt = geom0_r[31:16]; // RULE_10
      end
      icw_pkg::W_SPT: begin
        word_nxt = spt_r; // RULE_10
      end
      icw_pkg::W_CAPLO: begin
        word_nxt = cap_r[15:0]; // RULE_10
      end
      icw_pkg::W_CAPHI: begin
        word_nxt = cap_r[31:16]; // RULE_10
      end
      icw_pkg::W_MULT: begin
        word_nxt[icw_pkg::MULT_VALID_BIT] = 1'b1; // RULE_11
        word_nxt[7:0] = ctrl_r[icw_pkg::CTRL_MULT_LSB +: 8]; // RULE_11
      end
      icw_pkg::W_LBALO: begin
        word_nxt = lba_r[15:0]; // RULE_12
      end
      icw_pkg::W_LBAHI: begin
        word_nxt = lba_r[31:16]; // RULE_12
      end
      icw_pkg::W_MWDMA: begin
        // Faster DMA modes belong to another word, never here
        word_nxt[icw_pkg::MW_SEL_LSB +: MW_MODES_W] = mw_onehot; // RULE_13 RULE_15
        word_nxt[MW_MODES_W-1:0] = mw_sup; // RULE_14 RULE_15
      end
      icw_pkg::W_APIO: begin
        word_nxt[1:0] = apio; // RULE_16
      end
      icw_pkg::W_DMAMIN: begin
        word_nxt = w_dmamin;
      end
      icw_pkg::W_DMAREC: begin
        word_nxt = w_dmarec;
      end
      icw_pkg::W_PIONF: begin
        word_nxt = w_pionf;
      end
      icw_pkg::W_PIOIO: begin
        word_nxt = w_pioio;
      end
      default: begin
        word_nxt = 16'h0000;
      end
    endcase
  end

  // Identify read port, one cycle latency
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      id_data_r <= 16'h0000;
      id_vld_r <= 1'b0;
    end else begin
      id_vld_r <= id_rd_i;
      if (id_rd_i) begin
        id_data_r <= word_nxt;
      end
    end
  end

  // APB read data and error decode, evaluated in the setup phase
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr_i)
      icw_pkg::OFF_CTRL: begin
        rdata_nxt = ctrl_r;
      end
      icw_pkg::OFF_GEOM0: begin
        rdata_nxt = geom0_r;
      end
      icw_pkg::OFF_GEOM1: begin
        rdata_nxt = {16'h0000, spt_r};
      end
      icw_pkg::OFF_LBA: begin
        rdata_nxt = lba_r;
      end
      icw_pkg::OFF_DMACYC: begin
        rdata_nxt = dmacyc_r;
      end
      icw_pkg::OFF_PIOCYC: begin
        rdata_nxt = piocyc_r;
      end
      icw_pkg::OFF_STATUS: begin
        rdata_nxt = {16'h0000, w_valid};
        err_nxt = pwrite_i; // Read only
      end
      icw_pkg::OFF_CAP: begin
        rdata_nxt = cap_r;
        err_nxt = pwrite_i; // Read only
      end
      default: begin
        err_nxt = 1'b1;
      end
    endcase
  end

  // Fixed one-cycle access phase keeps every APB output on a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel_i & ~penable_i;
      if (psel_i & ~penable_i) begin
        pslverr_r <= err_nxt;
        prdata_r <= pwrite_i ? 32'h0000_0000 : rdata_nxt;
      end else if (pready_r) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign id_data_o = id_data_r;
  assign id_vld_o = id_vld_r;

endmodule

// File: testbench/icw_host_model.sv
// Purpose: Host side that fetches identify words from the generator
// Assumes: One request at a time, answer comes a cycle later
// Notes: Index is scrambled once released so stale values never look valid
`timescale 1ns/1ps
module icw_host_model (
  input wire logic clk_i,
  output logic id_rd_o,
  output logic [7:0] id_idx_o,
  input wire logic [15:0] id_data_i,
  input wire logic id_vld_i
);
  initial begin
    id_rd_o = 1'b0;
    id_idx_o = 8'h00;
  end

  // DMA pacing at the recommended cycle is up to the host, not this port
  task automatic rd(input logic [7:0] idx, output logic [15:0] d);
    @(posedge clk_i);
    id_rd_o <= 1'b1;
    id_idx_o <= idx;
    @(posedge clk_i);
    id_rd_o <= 1'b0;
    id_idx_o <= ~idx;
    do @(posedge clk_i); while (id_vld_i !== 1'b1);
    d = id_data_i;
  endtask
endmodule

// File: testbench/icw_checker.sv
// Purpose: Port-level checks of the identify word generator
// Assumes: Words appear one cycle after the request edge
// Notes: Word checks key on the index sampled at the request edge
`timescale 1ns/1ps
module icw_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic id_rd_i,
  input wire logic [7:0] id_idx_i,
  input wire logic [15:0] id_data_o,
  input wire logic id_vld_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // A word answer and the index it was asked for
  sequence s_word(logic [7:0] w);
    id_vld_o && $past(id_idx_i) == w;
  endsequence
  sequence s_setup;
    psel_i && !penable_i;
  endsequence

  a_ready_next: assert property (s_setup |=> pready_o)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  a_vld_lag: assert property (id_vld_o == $past(id_rd_i))
    else $error("word valid not one cycle after request");
  a_cap_fixed: assert property (
    s_word(icw_pkg::W_CAPAB) |-> id_data_o[10:8] == 3'h2) else $error("capability fixed bits");
  a_pio_code: assert property (
    s_word(icw_pkg::W_PIOMODE) |-> id_data_o[15:8] <= 8'h02 && id_data_o[7:0] == 8'h00)
    else $error("pio mode code");
  a_valid_geom: assert property (
    s_word(icw_pkg::W_VALID) |-> id_data_o[0] && id_data_o[15:2] == 14'h0)
    else $error("validity word");
  a_mult_form: assert property (
    s_word(icw_pkg::W_MULT) |-> id_data_o[15:8] == 8'h01) else $error("multiple word");
  a_dma_hot: assert property (
    s_word(icw_pkg::W_MWDMA) |-> $onehot0(id_data_o[15:8]) && id_data_o[15:11] == 5'h0
    && id_data_o[7:3] == 5'h0) else $error("dma word form");
  a_apio_res: assert property (
    s_word(icw_pkg::W_APIO) |-> id_data_o[15:2] == 14'h0) else $error("adv pio reserved");
endmodule

bind icw_top icw_checker i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .id_rd_i(id_rd_i),
  .id_idx_i(id_idx_i), .id_data_o(id_data_o), .id_vld_o(id_vld_o));

// File: testbench/tb_top.sv
// Purpose: Directed register and identify word tests
// Assumes: APB master waits for ready, byte strobes all set
// Notes: Expected words are worked out from the chosen register map
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, id_rd, id_vld;
  logic [7:0] id_idx;
  logic [15:0] id_data;
  int error_cnt = 0;
  int checks_done = 0;

  initial forever #5 clk = ~clk;

  icw_top i_dut (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .id_rd_i(id_rd),
    .id_idx_i(id_idx), .id_data_o(id_data), .id_vld_o(id_vld));
  icw_host_model i_host (.clk_i(clk), .id_rd_o(id_rd), .id_idx_o(id_idx),
    .id_data_i(id_data), .id_vld_i(id_vld));

  // One transfer; an idle edge first keeps releases and setups apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d, rd, er);
    `CHK(er, ee)
  endtask

  task automatic idw(input logic [7:0] i, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd(i, d);
    `CHK(d, e)
  endtask

  task automatic final_report;
    $display("Mismatches %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  initial begin
    #50us;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, icw_pkg::OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, icw_pkg::CTRL_RST)
    idw(8'd49, 16'h0200);
    idw(8'd53, 16'h0001);
    // Basic PIO codes, mode 3 clamps to 2
    for (int m = 0; m < 4; m++) begin
      wr(icw_pkg::OFF_CTRL, 32'(m << 2), 1'b0);
      idw(8'd51, 16'(((m > 2) ? 2 : m) << 8));
    end
    // Each DMA support level with the fastest allowed mode selected
    for (int l = 0; l < 4; l++) begin
      wr(icw_pkg::OFF_CTRL, 32'((l << 6) | (((l + 3) % 4) << 8)), 1'b0);
      idw(8'd63, 16'(((1 << l) - 1) | (l > 0 ? (16'h0080 << l) : 0)));
      idw(8'd53, (l > 0) ? 16'h0003 : 16'h0001);
    end
    wr(icw_pkg::OFF_CTRL, 32'h0010_01ff, 1'b0);
    wr(icw_pkg::OFF_DMACYC, 32'h0064_0078, 1'b0);
    wr(icw_pkg::OFF_PIOCYC, 32'h0078_0064, 1'b0);
    idw(8'd49, 16'h2a00);
    idw(8'd51, 16'h0200);
    idw(8'd53, 16'h0003);
    idw(8'd59, 16'h0110);
    idw(8'd63, 16'h0207);
    idw(8'd64, 16'h0003);
    idw(8'd65, 16'd120);
    idw(8'd66, 16'd120);
    idw(8'd67, 16'd120);
    idw(8'd68, 16'd120);
    // Recommended above minimum passes through; no-flow above IORDY is kept
    wr(icw_pkg::OFF_DMACYC, 32'h0096_0078, 1'b0);
    wr(icw_pkg::OFF_PIOCYC, 32'h0078_00b4, 1'b0);
    idw(8'd66, 16'd150);
    idw(8'd67, 16'd180);
    idw(8'd68, 16'd120);
    // Advanced PIO alone still validates words 64-70
    wr(icw_pkg::OFF_CTRL, 32'h0000_0010, 1'b0);
    idw(8'd53, 16'h0003);
    idw(8'd63, 16'h0000);
    idw(8'd65, 16'h0000);
    idw(8'd67, 16'd180);
    // DMA mode 0 only, no advanced PIO: cycle fields go to zero
    wr(icw_pkg::OFF_CTRL, 32'h0000_0040, 1'b0);
    for (int w = 65; w < 69; w++) idw(8'(w), 16'h0000);
    wr(icw_pkg::OFF_GEOM0, 32'h0010_03e8, 1'b0);
    wr(icw_pkg::OFF_GEOM1, 32'h0000_003f, 1'b0);
    wr(icw_pkg::OFF_LBA, 32'h0012_3456, 1'b0);
    idw(8'd54, 16'h03e8);
    idw(8'd55, 16'h0010);
    idw(8'd56, 16'h003f);
    idw(8'd57, 16'h6180);
    idw(8'd58, 16'h000f);
    idw(8'd60, 16'h3456);
    idw(8'd61, 16'h0012);
    apb(1'b0, icw_pkg::OFF_CAP, 32'h0, rd, er);
    `CHK(rd, 32'h000f_6180)
    // Read-only and unmapped places refuse
    wr(icw_pkg::OFF_CAP, 32'h0, 1'b1);
    wr(8'h20, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    // Reset in mid-run brings configuration and capacity back to defaults
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, icw_pkg::OFF_CTRL, 32'h0, rd, er);
    `CHK(rd, icw_pkg::CTRL_RST)
    idw(8'd53, 16'h0001);
    idw(8'd57, 16'h0000);
    final_report();
  end
endmodule
